// ===== csl_pkg.sv
// Package for the controller status lamp sequencer: states and cadences.
// Assumes a single 20 MHz system clock.
package csl_pkg;
  // ****************************************************************
  // Clock and cadence timing
  // ****************************************************************
  localparam int CLK_HZ = 20000000;
  localparam int FLASH_PERIOD_MS = 1000;
  localparam int RAPID_PERIOD_MS = 200;
  localparam int PULSE_MS = 200;
  localparam int GAP_MS = 200;
  localparam int FLASH_CYC = CLK_HZ / 1000 * FLASH_PERIOD_MS / 2;
  localparam int RAPID_CYC = CLK_HZ / 1000 * RAPID_PERIOD_MS / 2;
  localparam int PULSE_CYC = CLK_HZ / 1000 * PULSE_MS;
  localparam int GAP_CYC = CLK_HZ / 1000 * GAP_MS;
  localparam int CNT_W = 24;
  // Slots of the pulse sequencer: slot = one pulse or one gap time
  localparam logic [3:0] SLOT_LAST = 4'h9;
  localparam logic [3:0] SLOT_P1 = 4'h0;
  localparam logic [3:0] SLOT_P2 = 4'h2;
  localparam logic [3:0] SLOT_P3 = 4'h4;

  // ****************************************************************
  // Controller states
  // ****************************************************************
  typedef enum logic [3:0] {
    CSL_BOOTING, CSL_BAD_OS, CSL_EMPTY, CSL_RUNNING, CSL_STOPPED,
    CSL_HALT, CSL_HALT_SYS, CSL_REBOOT_HW
  } csl_state_t;
endpackage

// ===== csl_tick_if.sv
// Interface carrying cadence phases from the tick generator to the top.
// Assumes both ends share clock_in.
`timescale 1ns/1ps
`default_nettype none
interface csl_tick_if;
  logic flash_ph;
  logic rapid_ph;
  logic single_ph;
  logic triple_ph;
  modport gen (output flash_ph, rapid_ph, single_ph, triple_ph);
  modport use_ (input flash_ph, rapid_ph, single_ph, triple_ph);
endinterface
`default_nettype wire

// ===== csl_cadence.sv
// Cadence generator: free-running flash, rapid, single and triple phases.
// Assumes synchronous active-high reset on clock_in.
`timescale 1ns/1ps
`default_nettype none
module csl_cadence
  import csl_pkg::*;
(
  input wire logic clock_in, // System clock
  input wire logic reset_in, // Sync reset, active high
  csl_tick_if.gen tick       // Cadence phases out
);
  logic [CNT_W-1:0] flash_q, flash_d;
  logic [CNT_W-1:0] rapid_q, rapid_d;
  logic [CNT_W-1:0] slot_cnt_q, slot_cnt_d;
  logic [3:0] slot_q, slot_d;
  logic flash_ph_q, rapid_ph_q;
  wire flash_wrap = (flash_q == CNT_W'(FLASH_CYC - 1));
  wire rapid_wrap = (rapid_q == CNT_W'(RAPID_CYC - 1));
  wire slot_wrap = (slot_cnt_q == CNT_W'(PULSE_CYC - 1));

  // Separate counters so the rapid rate stays faster than flash [RULE15]
  assign flash_d = flash_wrap ? '0 : flash_q + CNT_W'(1);
  assign rapid_d = rapid_wrap ? '0 : rapid_q + CNT_W'(1);
  assign slot_cnt_d = slot_wrap ? '0 : slot_cnt_q + CNT_W'(1);
  assign slot_d = !slot_wrap ? slot_q :
                  (slot_q == SLOT_LAST) ? 4'h0 : slot_q + 4'h1;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      flash_q <= '0;
      rapid_q <= '0;
      slot_cnt_q <= '0;
      slot_q <= 4'h0;
      flash_ph_q <= 1'b0;
      rapid_ph_q <= 1'b0;
    end else begin
      flash_q <= flash_d;
      rapid_q <= rapid_d;
      slot_cnt_q <= slot_cnt_d;
      slot_q <= slot_d;
      if (flash_wrap) flash_ph_q <= ~flash_ph_q;
      if (rapid_wrap) rapid_ph_q <= ~rapid_ph_q;
    end
  end

  // Patterns repeat forever on the slot sequence [RULE15]
  assign tick.flash_ph = flash_ph_q;
  assign tick.rapid_ph = rapid_ph_q;
  assign tick.single_ph = (slot_q == SLOT_P1);
  assign tick.triple_ph = (slot_q == SLOT_P1) || (slot_q == SLOT_P2) ||
                          (slot_q == SLOT_P3);
endmodule
`default_nettype wire

// ===== csl_status_lamps.sv
// Status lamp sequencer: controller state machine and lamp patterns.
// Assumes state flags come from controller logic, synchronous to clock_in.
// Function
// [RULE1] Boot: self tests and checksum checks; no execution, no comms.
// [RULE2] Booting flashes the module status lamp green and red alternately.
// [RULE3] Bad_os_state: bad-OS state, red flash, restricted comms, no execution.
// [RULE4] Bad application or hardware fault: empty, single green flash, comms.
// [RULE5] Run: steady green; breakpoint: triple green flash, restricted run.
// [RULE6] Stopped: green flash, restricted comms, no execution.
// [RULE7] Application or system error: halt, single red flash, comms allowed. Code: a system error in stopped, running or halt goes to CSL_HALT_SYS instead.
// [RULE8] Halt on system error: steady red, no comms, no execution.
// [RULE9] Reboot after hardware fault: rapid red flash, comms, then empty.
// [RULE10] Running with external or boot-project error: green plus single red.
// [RULE11] Stopped with external error: green flash plus single red flash.
// [RULE12] Battery lamp steady red when battery needs replacement.
// [RULE13] Identify request blinks the front-panel lamps.
// [RULE14] Three green power lamps each follow their sensed 24 V input.
// [RULE15] Counter cadences; rapid faster than flash; patterns repeat.
`timescale 1ns/1ps
`default_nettype none
module csl_status_lamps
  import csl_pkg::*;
(
  input wire logic clock_in,        // System clock, 20 MHz
  input wire logic reset_in,        // Sync reset, active high
  input wire logic self_test_done_in, // Self tests finished
  input wire logic fw_crc_ok_in,    // Firmware checksum verified good
  input wire logic os_valid_in,     // Operating system valid
  input wire logic app_valid_in,    // User application checksum good
  input wire logic hw_fault_in,     // Hardware fault detected
  input wire logic start_in,        // Run command
  input wire logic stop_in,         // Stop command
  input wire logic breakpoint_in,   // Breakpoint active
  input wire logic app_error_in,    // Application error detected
  input wire logic sys_error_in,    // System error detected
  input wire logic ext_error_in,    // External error detected
  input wire logic boot_mismatch_in, // Boot project differs or absent
  input wire logic reboot_done_in,  // Hardware-fault reboot finished
  input wire logic battery_low_in,  // RTC battery needs replacing
  input wire logic identify_in,     // Identify request active
  input wire logic pwr_main_in,     // Main 24 V present
  input wire logic pwr_exp_in,      // Expert I/O 24 V present
  input wire logic pwr_io_in,       // I/O segment 24 V present
  output logic ms_green_out,        // Module status lamp green
  output logic ms_red_out,          // Module status lamp red
  output logic battery_red_out,     // Battery lamp
  output logic [2:0] pdu_green_out, // Power lamps: main, expert, I/O
  output logic comm_allow_out,      // Programming port open
  output logic comm_restrict_out,   // Programming port restricted
  output logic app_exec_out,        // Application may execute
  output logic exec_restrict_out    // Execution restricted
);
  csl_tick_if tick ();
  csl_cadence u_cadence (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .tick(tick)
  );

  // ****************************************************************
  // Controller state machine
  // ****************************************************************
  csl_state_t state_q, state_d;
  wire boot_ok = self_test_done_in && fw_crc_ok_in; // [RULE1]

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CSL_BOOTING: begin
        if (boot_ok) begin
          if (!os_valid_in) state_d = CSL_BAD_OS; // [RULE3]
          else if (hw_fault_in) state_d = CSL_REBOOT_HW; // [RULE9]
          else if (!app_valid_in) state_d = CSL_EMPTY; // [RULE4]
          else state_d = CSL_STOPPED;
        end
      end
      CSL_BAD_OS: state_d = CSL_BAD_OS; // [RULE3]
      CSL_REBOOT_HW: if (reboot_done_in) state_d = CSL_EMPTY; // [RULE9]
      CSL_EMPTY: if (app_valid_in && !hw_fault_in) state_d = CSL_STOPPED;
      CSL_STOPPED: begin
        if (sys_error_in) state_d = CSL_HALT_SYS;
        else if (app_error_in) state_d = CSL_HALT;
        else if (start_in) state_d = CSL_RUNNING;
      end
      CSL_RUNNING: begin
        // Errors outrank stop so a fault is never masked by a stop
        if (sys_error_in) state_d = CSL_HALT_SYS; // [RULE8]
        else if (app_error_in) state_d = CSL_HALT; // [RULE7]
        else if (stop_in) state_d = CSL_STOPPED;
      end
      CSL_HALT: begin
        if (sys_error_in) state_d = CSL_HALT_SYS;
        else if (stop_in) state_d = CSL_STOPPED;
      end
      CSL_HALT_SYS: state_d = CSL_HALT_SYS; // Only reset leaves it
      default: state_d = CSL_BOOTING;
    endcase
  end

  // ****************************************************************
  // Lamp pattern decode
  // ****************************************************************
  wire fl = tick.flash_ph;
  wire sg = tick.single_ph;
  wire tr = tick.triple_ph;
  wire rp = tick.rapid_ph;
  wire is_run = (state_q == CSL_RUNNING);
  wire is_stop = (state_q == CSL_STOPPED);
  wire run_bp = is_run && breakpoint_in;
  wire run_over = is_run && !breakpoint_in &&
                  (ext_error_in || boot_mismatch_in);
  wire stop_over = is_stop && ext_error_in;
  logic grn, red;

  always_comb begin
    grn = 1'b0;
    red = 1'b0;
    unique case (state_q)
      CSL_BOOTING: begin
        grn = fl; // [RULE2]
        red = !fl; // [RULE2]
      end
      CSL_BAD_OS: red = fl; // [RULE3]
      CSL_EMPTY: grn = sg; // [RULE4]
      CSL_RUNNING: begin
        // Red pulse replaces green so both colours never mix
        grn = run_bp ? tr : (run_over ? !sg : 1'b1); // [RULE5] [RULE10]
        red = run_over && sg; // [RULE10]
      end
      CSL_STOPPED: begin
        grn = stop_over ? (fl && !sg) : fl; // [RULE6] [RULE11]
        red = stop_over && sg; // [RULE11]
      end
      CSL_HALT: red = sg; // [RULE7]
      CSL_HALT_SYS: red = 1'b1; // [RULE8]
      CSL_REBOOT_HW: red = rp; // [RULE9]
      default: begin
        grn = 1'b0;
        red = 1'b0;
      end
    endcase
  end

  // Identify forces a common blink on the module status and battery lamps [RULE13]
  wire ms_g_d = identify_in ? fl : grn;
  wire ms_r_d = identify_in ? 1'b0 : red;
  wire bat_d = identify_in ? fl : battery_low_in; // [RULE12]

  // ****************************************************************
  // Communication and execution permissions
  // ****************************************************************
  wire comm_d = (state_q == CSL_EMPTY) || is_run ||
                (state_q == CSL_HALT) || (state_q == CSL_REBOOT_HW);
  wire restrict_d = (state_q == CSL_BAD_OS) || is_stop; // [RULE3] [RULE6]
  wire exec_d = is_run; // [RULE1] [RULE4] [RULE7] [RULE8]
  wire exec_r_d = run_bp; // [RULE5]

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_q <= CSL_BOOTING;
      ms_green_out <= 1'b0;
      ms_red_out <= 1'b0;
      battery_red_out <= 1'b0;
      pdu_green_out <= 3'h0;
      comm_allow_out <= 1'b0;
      comm_restrict_out <= 1'b0;
      app_exec_out <= 1'b0;
      exec_restrict_out <= 1'b0;
    end else begin
      state_q <= state_d;
      ms_green_out <= ms_g_d;
      ms_red_out <= ms_r_d;
      battery_red_out <= bat_d;
      pdu_green_out <= {pwr_io_in, pwr_exp_in, pwr_main_in}; // [RULE14]
      comm_allow_out <= comm_d;
      comm_restrict_out <= restrict_d;
      app_exec_out <= exec_d;
      exec_restrict_out <= exec_r_d;
    end
  end
endmodule
`default_nettype wire

// ===== csl_lamps_assertions.sv
// Checker: lamp and port-permission relations on the lamp sequencer's ports.
// Assumes it is bound onto csl_status_lamps, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module csl_lamps_assertions (
  input wire logic clock_in, // Clock
  input wire logic reset_in, // Sync reset
  input wire logic battery_low_in, // Battery flag
  input wire logic identify_in, // Identify
  input wire logic pwr_main_in, // Main 24 V
  input wire logic pwr_exp_in, // Expert 24 V
  input wire logic pwr_io_in, // I/O 24 V
  input wire logic breakpoint_in, // Breakpoint
  input wire logic ext_error_in, // External error
  input wire logic boot_mismatch_in, // Boot project
  input wire logic sys_error_in, // System error
  input wire logic ms_green_out, // Green lamp
  input wire logic ms_red_out, // Red lamp
  input wire logic battery_red_out, // Battery lamp
  input wire logic [2:0] pdu_green_out, // Power lamps
  input wire logic comm_allow_out, // Port open
  input wire logic comm_restrict_out, // Port restricted
  input wire logic app_exec_out, // Executing
  input wire logic exec_restrict_out // Restricted run
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  property p_battery;
    !$past(reset_in) && !$past(identify_in) |->
      battery_red_out == $past(battery_low_in);
  endproperty
  a_battery: assert property (p_battery)
    else $error("battery lamp");
  property p_power;
    !$past(reset_in) |-> pdu_green_out ==
      {$past(pwr_io_in), $past(pwr_exp_in), $past(pwr_main_in)};
  endproperty
  a_power: assert property (p_power)
    else $error("power lamps");
  // A bicolour lamp: green and red never lit together
  property p_one_colour;
    !(ms_green_out && ms_red_out);
  endproperty
  a_one_colour: assert property (p_one_colour)
    else $error("two colours");
  property p_comm_excl;
    !(comm_allow_out && comm_restrict_out);
  endproperty
  a_comm_excl: assert property (p_comm_excl)
    else $error("comm both");
  property p_exec_comm;
    app_exec_out |-> comm_allow_out;
  endproperty
  a_exec_comm: assert property (p_exec_comm)
    else $error("exec no comm");
  property p_bp_comm;
    exec_restrict_out |-> comm_allow_out && !comm_restrict_out;
  endproperty
  a_bp_comm: assert property (p_bp_comm)
    else $error("breakpoint comm");
  property p_run_green;
    app_exec_out && !$past(identify_in) && !$past(ext_error_in) &&
      !$past(boot_mismatch_in) && !$past(breakpoint_in) |->
      ms_green_out && !ms_red_out;
  endproperty
  a_run_green: assert property (p_run_green)
    else $error("run lamp");
  // Identify overrides the lamp, so it is left out of the halt check
  property p_sys_halt;
    app_exec_out && sys_error_in ##1 !identify_in |->
      ##1 ms_red_out && !ms_green_out && !comm_allow_out && !app_exec_out;
  endproperty
  a_sys_halt: assert property (p_sys_halt)
    else $error("system halt");
endmodule
bind csl_status_lamps csl_lamps_assertions u_csl_lamps_assertions (
  .clock_in, .reset_in, .battery_low_in, .identify_in, .pwr_main_in,
  .pwr_exp_in, .pwr_io_in, .breakpoint_in, .ext_error_in, .boot_mismatch_in,
  .sys_error_in, .ms_green_out, .ms_red_out, .battery_red_out, .pdu_green_out,
  .comm_allow_out, .comm_restrict_out, .app_exec_out, .exec_restrict_out);
`default_nettype wire

// ===== csl_lamp_panel.sv
// Operator panel model: counts cycles in which the status lamp is lit.
// Assumes lamp drives are high when lit.
`timescale 1ns/1ps
`default_nettype none
module csl_lamp_panel (
  input wire logic clock_in, // Clock
  input wire logic ms_green_in, // Green lamp
  input wire logic ms_red_in, // Red lamp
  output int glow_count // Lit cycles seen
);
  initial glow_count = 0;
  always @(posedge clock_in) begin
    if (ms_green_in || ms_red_in) begin
      glow_count <= glow_count + 1;
    end
  end
endmodule
`default_nettype wire

// ===== csl_status_lamps_tb.sv
// Testbench: boots into each state and checks lamps and port permissions.
// Assumes cadences far longer than the run: flash low, first slot lit.
`timescale 1ns/1ps
`default_nettype none
module csl_status_lamps_tb;
  logic clock_in = 1'b0, reset_in = 1'b1, self_test_done_in = 1'b0;
  logic fw_crc_ok_in = 1'b0, os_valid_in = 1'b0, app_valid_in = 1'b0;
  logic hw_fault_in = 1'b0, start_in = 1'b0, stop_in = 1'b0;
  logic breakpoint_in = 1'b0, app_error_in = 1'b0, sys_error_in = 1'b0;
  logic ext_error_in = 1'b0, boot_mismatch_in = 1'b0, reboot_done_in = 1'b0;
  logic battery_low_in = 1'b0, identify_in = 1'b0, pwr_main_in = 1'b0;
  logic pwr_exp_in = 1'b0, pwr_io_in = 1'b0;
  logic ms_green_out, ms_red_out, battery_red_out, comm_allow_out;
  logic comm_restrict_out, app_exec_out, exec_restrict_out;
  logic [2:0] pdu_green_out;
  int err_count = 0, n_compared = 0, cyc = 0, glow, glow0, rnd;
  csl_status_lamps u_csl_status_lamps (.clock_in, .reset_in,
    .self_test_done_in, .fw_crc_ok_in, .os_valid_in, .app_valid_in,
    .hw_fault_in, .start_in, .stop_in, .breakpoint_in, .app_error_in,
    .sys_error_in, .ext_error_in, .boot_mismatch_in, .reboot_done_in,
    .battery_low_in, .identify_in, .pwr_main_in, .pwr_exp_in, .pwr_io_in,
    .ms_green_out, .ms_red_out, .battery_red_out, .pdu_green_out,
    .comm_allow_out, .comm_restrict_out, .app_exec_out, .exec_restrict_out);
  csl_lamp_panel u_csl_lamp_panel (.clock_in, .ms_green_in(ms_green_out),
    .ms_red_in(ms_red_out), .glow_count(glow));
  always #25 clock_in = ~clock_in;
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  // Permission code {allow, restrict, exec} and lamp code {green, red}
  task automatic perm(input logic [2:0] exp);
    chk({1'b0, comm_allow_out, comm_restrict_out, app_exec_out}, {1'b0, exp});
  endtask
  task automatic lamps(input logic [1:0] exp);
    chk({2'b00, ms_green_out, ms_red_out}, {2'b00, exp});
  endtask
  task automatic boot(input logic os, input logic app, input logic hw);
    reset_in = 1'b1;
    {self_test_done_in, fw_crc_ok_in, start_in, sys_error_in} = 4'h0;
    step(5);
    lamps(2'b00);
    perm(3'b000);
    reset_in = 1'b0;
    step(1);
    lamps(2'b01);
    perm(3'b000);
    {self_test_done_in, fw_crc_ok_in} = 2'b11;
    {os_valid_in, app_valid_in, hw_fault_in} = {os, app, hw};
    step(3);
  endtask
  initial begin
    void'($urandom(92));
    boot(1'b0, 1'b1, 1'b0);
    perm(3'b010);
    start_in = 1'b1;
    step(3);
    perm(3'b010);
    boot(1'b1, 1'b1, 1'b1);
    perm(3'b100);
    reboot_done_in = 1'b1;
    step(3);
    perm(3'b100);
    reboot_done_in = 1'b0;
    boot(1'b1, 1'b0, 1'b0);
    perm(3'b100);
    lamps(2'b10);
    boot(1'b1, 1'b1, 1'b0);
    perm(3'b010);
    ext_error_in = 1'b1;
    step(3);
    perm(3'b010);
    lamps(2'b01);
    ext_error_in = 1'b0;
    repeat (16) begin
      rnd = $urandom;
      {battery_low_in, pwr_io_in, pwr_exp_in, pwr_main_in} = rnd[3:0];
      step(1);
      chk({battery_red_out, pdu_green_out}, rnd[3:0]);
    end
    start_in = 1'b1;
    step(1);
    start_in = 1'b0;
    step(2);
    perm(3'b101);
    lamps(2'b10);
    boot_mismatch_in = 1'b1;
    step(3);
    perm(3'b101);
    lamps(2'b01);
    boot_mismatch_in = 1'b0;
    breakpoint_in = 1'b1;
    step(3);
    chk({2'b00, comm_allow_out, exec_restrict_out}, 4'h3);
    lamps(2'b10);
    breakpoint_in = 1'b0;
    identify_in = 1'b1;
    battery_low_in = 1'b1;
    step(3);
    lamps(2'b00);
    chk({3'b000, battery_red_out}, 4'h0);
    identify_in = 1'b0;
    app_error_in = 1'b1;
    step(3);
    perm(3'b100);
    app_error_in = 1'b0;
    sys_error_in = 1'b1;
    step(3);
    perm(3'b000);
    lamps(2'b01);
    glow0 = glow;
    step(4);
    chk(4'(glow - glow0), 4'h4);
    // System error straight out of running
    boot(1'b1, 1'b1, 1'b0);
    start_in = 1'b1;
    step(1);
    start_in = 1'b0;
    step(2);
    sys_error_in = 1'b1;
    step(3);
    perm(3'b000);
    lamps(2'b01);
    wrap_up();
  end
endmodule
`default_nettype wire
